// file: pkg/hcs_pkg.sv
// Package for the link control and status block of the embedded framer
package hcs_pkg;
  localparam logic [7:0] HCS_OFF_DATA = 8'h12;
  localparam logic [7:0] HCS_OFF_CTRL = 8'h13;
  localparam logic [7:0] HCS_OFF_STAT = 8'h14;
  localparam logic [7:0] HCS_CTRL_RST = 8'h00;
  localparam int HCS_B_ADREC = 7;
  localparam int HCS_B_RECEIVER_ENABLE = 6;
  localparam int HCS_B_TRANSMITTER_ENABLE = 5;
  localparam int HCS_B_LAST = 4;
  localparam int HCS_B_ABORT = 3;
  localparam int HCS_B_FILL = 2;
  localparam logic [7:0] HCS_CTRL_WMASK = 8'hFC;
  localparam int HCS_IDLE_RUN = 15;
  localparam logic [4:0] HCS_IDLE_MAX = 5'h0F;
  localparam logic [6:0] HCS_ALL_CALL = 7'h7F;
  localparam int HCS_FIFO_DEPTH = 16;
  localparam int HCS_CNT_W = 5;
  localparam logic [7:0] HCS_FLAG = 8'h7E;
  localparam logic [1:0] HCS_TAG_MID = 2'h0;
  localparam logic [1:0] HCS_TAG_FIRST = 2'h1;
  localparam logic [1:0] HCS_TAG_GOOD = 2'h2;
  localparam logic [1:0] HCS_TAG_BAD = 2'h3;
  localparam logic [1:0] HCS_TX_FULL = 2'h0;
  localparam logic [1:0] HCS_TX_ATTH = 2'h1;
  localparam logic [1:0] HCS_TX_EMPTY = 2'h2;
  localparam logic [1:0] HCS_TX_BELOW = 2'h3;
  localparam logic [1:0] HCS_RX_EMPTY = 2'h0;
  localparam logic [1:0] HCS_RX_BELOW = 2'h1;
  localparam logic [1:0] HCS_RX_FULL = 2'h2;
  localparam logic [1:0] HCS_RX_ATTH = 2'h3;
  // One transmit FIFO entry: byte plus its two tags
  typedef struct packed {
    logic last;
    logic abort;
    logic [7:0] data;
  } hcs_tx_entry_s;
  // Host parallel port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hcs_host_s;
  typedef enum logic [2:0] {
    HCS_TX_OFF = 3'b001,
    HCS_TX_FILLING = 3'b010,
    HCS_TX_SEND = 3'b100
  } hcs_tx_state_e;
endpackage : hcs_pkg

// file: src/hcs_level_code.sv
// FIFO level encoder for the status register
`timescale 1ns/1ps
`default_nettype none
module hcs_level_code (
  // Fill level and thresholds
  input wire logic [4:0] count,
  input wire logic [4:0] thresh,
  input wire logic [4:0] full_lvl,
  input wire logic is_tx,
  // Code
  output logic [1:0] code
);
  wire empty_w = (count == 5'h00);
  wire full_w = (count >= full_lvl);
  wire atth_w = (count >= thresh);
  always_comb begin
    if (is_tx) begin
      if (full_w) code = hcs_pkg::HCS_TX_FULL;
      else if (atth_w) code = hcs_pkg::HCS_TX_ATTH;
      else if (empty_w) code = hcs_pkg::HCS_TX_EMPTY;
      else code = hcs_pkg::HCS_TX_BELOW;
    end else begin
      if (empty_w) code = hcs_pkg::HCS_RX_EMPTY;
      else if (full_w) code = hcs_pkg::HCS_RX_FULL;
      else if (atth_w) code = hcs_pkg::HCS_RX_ATTH;
      else code = hcs_pkg::HCS_RX_BELOW;
    end
  end
endmodule : hcs_level_code
`default_nettype wire

// file: src/hcs_top.sv
// Control and status logic of the embedded serial link controller
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - With address filtering on, only frames whose address matches the mask or is all-call are kept.
// - Setting receive enable starts the receiver at once hunting for flags.
// - Clearing receive enable lets the frame in progress finish before stopping.
// - Setting transmit enable starts sending queued data or else fill.
// - Clearing transmit enable lets the frame in progress finish before stopping.
// - The last-byte tag marks the next written byte as frame end, followed by the check sequence.
// - The abort tag marks the next written byte, and its frame is aborted.
// - Both tag bits clear themselves after each transmit FIFO write.
// - With the transmit FIFO empty, fill select picks mark idle or flag fill.
// - The interrupt status bit shows a masked interrupt raised by the controller.
// - The idle channel bit sets after fifteen or more ones in a row.
// - The receive byte tag codes middle, first, good last and bad last.
// - The transmit level code shows full, at threshold, empty or below.
// - The receive level code shows empty, below, full or at threshold.
// - Each transmit FIFO entry holds the byte with both tags, ten bits.
// - An address of seven ones is the all-call address.
module hcs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host parallel port
  input wire hcs_pkg::hcs_host_s host,
  output logic [7:0] host_rdata,
  // Serial bit stream, one bit per enable
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  input wire logic tx_bit_en,
  output logic tx_bit,
  // Receive byte path from the deserialiser
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_first,
  input wire logic rx_end,
  input wire logic rx_bad,
  input wire logic [6:0] addr_mask,
  // Context from the rest of the controller
  input wire logic irq_masked,
  input wire logic [4:0] thresh,
  input wire logic [4:0] full_lvl,
  // Status to the rest of the controller
  output logic rx_active,
  output logic tx_active,
  output logic tx_fcs_req,
  output logic tx_abort_req
);
  localparam int DW = hcs_pkg::HCS_FIFO_DEPTH;
  logic [7:0] ctrl_reg;
  logic [4:0] ones_reg;
  logic idle_reg;
  logic irq_reg;
  logic rx_on_reg;
  logic in_frame_reg;
  logic drop_reg;
  hcs_pkg::hcs_tx_entry_s tx_mem [DW];
  logic [3:0] tx_wp_reg, tx_rp_reg;
  logic [4:0] tx_cnt_reg;
  logic [9:0] rx_mem [DW];
  logic [3:0] rx_wp_reg, rx_rp_reg;
  logic [4:0] rx_cnt_reg;
  hcs_pkg::hcs_tx_state_e tx_state_reg, tx_state_next;
  hcs_pkg::hcs_tx_entry_s tx_cur_reg;
  logic [2:0] tx_bitn_reg;
  logic tx_bit_reg, tx_fcs_reg, tx_abort_reg;
  logic [1:0] tx_code, rx_code;
  hcs_pkg::hcs_tx_entry_s tx_tx_head;

  wire wr_ctrl = host.wr && host.addr == hcs_pkg::HCS_OFF_CTRL;
  wire wr_data = host.wr && host.addr == hcs_pkg::HCS_OFF_DATA;
  wire rd_data = host.rd && host.addr == hcs_pkg::HCS_OFF_DATA;
  wire tx_full = tx_cnt_reg == 5'(DW);
  wire tx_empty = tx_cnt_reg == 5'h00;
  wire rx_empty = rx_cnt_reg == 5'h00;
  wire rx_pop = rd_data && !rx_empty;
  wire tx_push = wr_data && !tx_full;
  wire tx_pop;
  wire rx_en = ctrl_reg[hcs_pkg::HCS_B_RECEIVER_ENABLE];
  wire tx_en = ctrl_reg[hcs_pkg::HCS_B_TRANSMITTER_ENABLE];
  wire adrec = ctrl_reg[hcs_pkg::HCS_B_ADREC];
  // First byte address check, all-call always passes
  wire addr_ok = !adrec || rx_byte[7:1] == addr_mask
    || rx_byte[7:1] == hcs_pkg::HCS_ALL_CALL;
  wire drop_now = rx_first ? !addr_ok : drop_reg;
  wire rx_push = rx_byte_valid && rx_on_reg && !drop_now
    && rx_cnt_reg != 5'(DW);
  wire [1:0] rx_tag_in = rx_end ? (rx_bad ? hcs_pkg::HCS_TAG_BAD
    : hcs_pkg::HCS_TAG_GOOD) : rx_first ? hcs_pkg::HCS_TAG_FIRST
    : hcs_pkg::HCS_TAG_MID;
  wire [9:0] rx_head = rx_mem[rx_rp_reg];
  wire [1:0] rx_tag = rx_empty ? hcs_pkg::HCS_TAG_MID : rx_head[9:8];
  wire [7:0] stat_w = {irq_reg, idle_reg, rx_tag, tx_code, rx_code};
  wire [7:0] ctrl_w = ctrl_reg & hcs_pkg::HCS_CTRL_WMASK;

  // Control register; tags fall after each FIFO write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= hcs_pkg::HCS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= host.wdata;
    end else if (wr_data) begin
      ctrl_reg[hcs_pkg::HCS_B_LAST] <= 1'b0;
      ctrl_reg[hcs_pkg::HCS_B_ABORT] <= 1'b0;
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
    end else if (host.rd) begin
      case (host.addr)
        hcs_pkg::HCS_OFF_DATA: host_rdata <= rx_head[7:0];
        hcs_pkg::HCS_OFF_CTRL: host_rdata <= ctrl_w;
        hcs_pkg::HCS_OFF_STAT: host_rdata <= stat_w;
        default: host_rdata <= 8'h00;
      endcase
    end
  end

  // Interrupt flag follows the masked interrupt level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_reg <= 1'b0;
    else irq_reg <= irq_masked;
  end

  // Run of ones for idle channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones_reg <= 5'h00;
      idle_reg <= 1'b0;
    end else if (rx_bit_en && rx_on_reg) begin
      if (!rx_bit) begin
        ones_reg <= 5'h00;
        idle_reg <= 1'b0;
      end else begin
        if (ones_reg != hcs_pkg::HCS_IDLE_MAX) ones_reg <= ones_reg + 5'h01;
        // The fifteenth one in a row already counts as idle
        if (ones_reg >= 5'(hcs_pkg::HCS_IDLE_RUN - 1)) begin
          idle_reg <= 1'b1;
        end
      end
    end
  end

  // Receiver enable: on at once, off only between frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_on_reg <= 1'b0;
      in_frame_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      if (rx_en) rx_on_reg <= 1'b1;
      else if (!in_frame_reg) rx_on_reg <= 1'b0;
      if (rx_byte_valid && rx_on_reg) begin
        in_frame_reg <= !rx_end;
        drop_reg <= rx_end ? 1'b0 : drop_now;
      end
    end
  end

  // Receive FIFO, ten bits per entry
  always_ff @(posedge clk) begin
    if (rx_push) rx_mem[rx_wp_reg] <= {rx_tag_in, rx_byte};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_reg <= 4'h0;
      rx_rp_reg <= 4'h0;
      rx_cnt_reg <= 5'h00;
    end else begin
      if (rx_push) rx_wp_reg <= rx_wp_reg + 4'h1;
      if (rx_pop) rx_rp_reg <= rx_rp_reg + 4'h1;
      rx_cnt_reg <= rx_cnt_reg + 5'(rx_push) - 5'(rx_pop);
    end
  end

  // Transmit FIFO, byte stored with both tags
  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= '{last: ctrl_reg[hcs_pkg::HCS_B_LAST],
        abort: ctrl_reg[hcs_pkg::HCS_B_ABORT], data: host.wdata};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_reg <= 4'h0;
      tx_rp_reg <= 4'h0;
      tx_cnt_reg <= 5'h00;
    end else begin
      if (tx_push) tx_wp_reg <= tx_wp_reg + 4'h1;
      if (tx_pop) tx_rp_reg <= tx_rp_reg + 4'h1;
      tx_cnt_reg <= tx_cnt_reg + 5'(tx_push) - 5'(tx_pop);
    end
  end

  // Transmit sequencer
  wire byte_done = tx_bit_en && tx_bitn_reg == 3'h7;
  wire in_pkt_reg_w = tx_state_reg == hcs_pkg::HCS_TX_SEND;
  assign tx_pop = tx_bit_en && tx_bitn_reg == 3'h7 && !tx_empty
    && (tx_state_reg == hcs_pkg::HCS_TX_FILLING
    || (in_pkt_reg_w && !tx_cur_reg.last && !tx_cur_reg.abort)
    || (in_pkt_reg_w && tx_en));
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      hcs_pkg::HCS_TX_OFF:
        if (tx_en) tx_state_next = hcs_pkg::HCS_TX_FILLING;
      hcs_pkg::HCS_TX_FILLING:
        if (byte_done && !tx_empty) tx_state_next = hcs_pkg::HCS_TX_SEND;
        else if (!tx_en) tx_state_next = hcs_pkg::HCS_TX_OFF;
      hcs_pkg::HCS_TX_SEND:
        if (byte_done && (tx_cur_reg.last || tx_cur_reg.abort)) begin
          if (!tx_en) tx_state_next = hcs_pkg::HCS_TX_OFF;
          else if (tx_empty) tx_state_next = hcs_pkg::HCS_TX_FILLING;
        end
      default: tx_state_next = hcs_pkg::HCS_TX_OFF;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= hcs_pkg::HCS_TX_OFF;
      tx_cur_reg <= '0;
      tx_bitn_reg <= 3'h0;
      tx_bit_reg <= 1'b1;
      tx_fcs_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_fcs_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
      if (tx_pop) tx_cur_reg <= tx_tx_head;
      if (tx_bit_en && tx_state_reg != hcs_pkg::HCS_TX_OFF) begin
        tx_bitn_reg <= tx_bitn_reg + 3'h1;
        if (tx_state_reg == hcs_pkg::HCS_TX_SEND) begin
          tx_bit_reg <= tx_cur_reg.data[tx_bitn_reg];
          if (tx_bitn_reg == 3'h7) begin
            tx_fcs_reg <= tx_cur_reg.last && !tx_cur_reg.abort;
            tx_abort_reg <= tx_cur_reg.abort;
          end
        end else if (ctrl_reg[hcs_pkg::HCS_B_FILL]) begin
          tx_bit_reg <= hcs_pkg::HCS_FLAG[tx_bitn_reg];
        end else begin
          tx_bit_reg <= 1'b1;
        end
      end else if (tx_state_reg == hcs_pkg::HCS_TX_OFF) begin
        tx_bitn_reg <= 3'h0;
        tx_bit_reg <= 1'b1;
      end
    end
  end
  assign tx_tx_head = tx_mem[tx_rp_reg];

  hcs_level_code u_tx_code (
    .count(tx_cnt_reg),
    .thresh(thresh),
    .full_lvl(full_lvl),
    .is_tx(1'b1),
    .code(tx_code)
  );
  hcs_level_code u_rx_code (
    .count(rx_cnt_reg),
    .thresh(thresh),
    .full_lvl(full_lvl),
    .is_tx(1'b0),
    .code(rx_code)
  );

  assign tx_bit = tx_bit_reg;
  assign tx_fcs_req = tx_fcs_reg;
  assign tx_abort_req = tx_abort_reg;
  assign rx_active = rx_on_reg;
  assign tx_active = tx_state_reg != hcs_pkg::HCS_TX_OFF;

  chk_tags_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_data && !wr_ctrl |=> !ctrl_reg[hcs_pkg::HCS_B_LAST]
    && !ctrl_reg[hcs_pkg::HCS_B_ABORT]) else $error("tag not cleared");
  chk_rx_start: assert property (@(posedge clk) disable iff (!rst_n)
    rx_en |=> rx_on_reg) else $error("receiver not enabled");
  chk_rx_finish: assert property (@(posedge clk) disable iff (!rst_n)
    in_frame_reg && rx_on_reg |=> rx_on_reg) else $error("rx cut mid frame");
  chk_tx_start: assert property (@(posedge clk) disable iff (!rst_n)
    tx_en && tx_state_reg == hcs_pkg::HCS_TX_OFF |=> tx_active)
    else $error("transmitter not enabled");
  chk_tx_finish: assert property (@(posedge clk) disable iff (!rst_n)
    in_pkt_reg_w && !byte_done |=> in_pkt_reg_w)
    else $error("tx cut mid frame");
  chk_idle_set: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(idle_reg) |-> $past(ones_reg) == 5'(hcs_pkg::HCS_IDLE_RUN - 1))
    else $error("idle set early");
  chk_irq_follow: assert property (@(posedge clk) disable iff (!rst_n)
    irq_masked |=> irq_reg) else $error("irq flag missing");
  chk_mark_fill: assert property (@(posedge clk) disable iff (!rst_n)
    tx_bit_en && tx_state_reg == hcs_pkg::HCS_TX_FILLING
    && !ctrl_reg[hcs_pkg::HCS_B_FILL] && !wr_ctrl |=> tx_bit)
    else $error("mark idle not ones");
  chk_rx_drop: assert property (@(posedge clk) disable iff (!rst_n)
    rx_byte_valid && rx_first && !addr_ok |-> !rx_push)
    else $error("bad address stored");
endmodule : hcs_top
`default_nettype wire

// file: sim/hcs_line_model.sv
// Serial line partner: bit timing and zero count on the transmit line
`timescale 1ns/1ps
`default_nettype none
module hcs_line_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control from the bench
  input wire logic clr,
  // Serial line
  input wire logic tx_bit,
  output logic tx_bit_en,
  output logic [7:0] zeros
);
  logic [1:0] div_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
      zeros <= 8'h00;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (clr) begin
        zeros <= 8'h00;
      end else if (tx_bit_en && !tx_bit) begin
        zeros <= zeros + 8'h01;
      end
    end
  end
  // One bit time every four clocks
  assign tx_bit_en = (div_reg == 2'h3);
endmodule : hcs_line_model
`default_nettype wire

// file: sim/hcs_top_test.sv
// Self-checking bench for the link control and status block
`timescale 1ns/1ps
`default_nettype none
module hcs_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  hcs_pkg::hcs_host_s host = '0;
  logic [7:0] host_rdata, zeros, rx_byte = 8'h00;
  logic rx_bit = 1'b1, rx_bit_en = 1'b0, rx_byte_valid = 1'b0;
  logic rx_first = 1'b0, rx_end = 1'b0, rx_bad = 1'b0;
  logic irq_masked = 1'b0, clr = 1'b0;
  logic [6:0] addr_mask = 7'h15;
  logic tx_bit_en, tx_bit, rx_active, tx_active, tx_fcs_req, tx_abort_req;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  hcs_top i_hcs_top (.clk(clk), .rst_n(rst_n), .host(host),
    .host_rdata(host_rdata), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
    .tx_bit_en(tx_bit_en), .tx_bit(tx_bit), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_first(rx_first), .rx_end(rx_end),
    .rx_bad(rx_bad), .addr_mask(addr_mask), .irq_masked(irq_masked),
    .thresh(5'h04), .full_lvl(5'h08), .rx_active(rx_active),
    .tx_active(tx_active), .tx_fcs_req(tx_fcs_req),
    .tx_abort_req(tx_abort_req));
  hcs_line_model i_hcs_line_model (.clk(clk), .rst_n(rst_n), .clr(clr),
    .tx_bit(tx_bit), .tx_bit_en(tx_bit_en), .zeros(zeros));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    host <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    host <= '0;
    tick();
    d = host_rdata;
  endtask : rd
  task automatic rxb(input logic [7:0] b, input logic f, input logic e,
                     input logic bd);
    @(posedge clk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    rx_first <= f;
    rx_end <= e;
    rx_bad <= bd;
    @(posedge clk);
    rx_byte_valid <= 1'b0;
  endtask : rxb
  task automatic rxbits(input int n, input logic b);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_bit <= b;
      rx_bit_en <= 1'b1;
      @(posedge clk);
      rx_bit_en <= 1'b0;
    end
  endtask : rxbits
  task automatic t_reset();
    logic [7:0] v;
    chk("tx idle line", {7'h00, tx_bit}, 8'h01);
    rd(hcs_pkg::HCS_OFF_CTRL, v);
    chk("control reset", v, hcs_pkg::HCS_CTRL_RST);
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("status reset", v, 8'h08);
    rd(8'h20, v);
    chk("unmapped read", v, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_txlev();
    logic [7:0] v;
    for (int i = 0; i < 3; i++) wr(hcs_pkg::HCS_OFF_DATA, 8'hA0 + 8'(i));
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("tx below", v, 8'h0C);
    wr(hcs_pkg::HCS_OFF_DATA, 8'hA3);
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("tx at threshold", v, 8'h04);
    for (int i = 4; i < 7; i++) wr(hcs_pkg::HCS_OFF_DATA, 8'hA0 + 8'(i));
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h10);
    rd(hcs_pkg::HCS_OFF_CTRL, v);
    chk("last tag set", v, 8'h10);
    wr(hcs_pkg::HCS_OFF_DATA, 8'hA7);
    rd(hcs_pkg::HCS_OFF_CTRL, v);
    chk("last tag cleared", v, 8'h00);
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("tx full", v, 8'h00);
    $display("test tx level done");
  endtask : t_txlev
  task automatic t_txrun();
    logic seen;
    logic held;
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h20);
    tick();
    tick();
    chk("tx starts", {7'h00, tx_active}, 8'h01);
    // Let the frame get under way, so the enable drops mid frame
    repeat (60) tick();
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h00);
    seen = 1'b0;
    held = 1'b1;
    for (int i = 0; i < 400 && !seen; i++) begin
      tick();
      seen = (tx_fcs_req === 1'b1);
      if (!seen) held &= (tx_active === 1'b1);
    end
    chk("check sequence asked", {7'h00, seen}, 8'h01);
    chk("tx held to frame end", {7'h00, held}, 8'h01);
    for (int i = 0; i < 200 && tx_active !== 1'b0; i++) tick();
    chk("tx stops", {7'h00, tx_active}, 8'h00);
    $display("test tx run done");
  endtask : t_txrun
  task automatic t_fill();
    logic [7:0] v;
    logic seen;
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h08);
    wr(hcs_pkg::HCS_OFF_DATA, 8'h55);
    rd(hcs_pkg::HCS_OFF_CTRL, v);
    chk("abort tag cleared", v, 8'h00);
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h20);
    seen = 1'b0;
    for (int i = 0; i < 100 && !seen; i++) begin
      tick();
      seen = (tx_abort_req === 1'b1);
    end
    chk("abort asked", {7'h00, seen}, 8'h01);
    repeat (8) tick();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (64) tick();
    chk("mark idle", zeros, 8'h00);
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h24);
    repeat (8) tick();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (64) tick();
    chk("flag fill", {7'h00, zeros != 8'h00}, 8'h01);
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h00);
    $display("test fill done");
  endtask : t_fill
  task automatic t_rx();
    logic [7:0] v;
    logic [7:0] eb [5] = '{8'h2A, 8'h11, 8'h22, 8'hFE, 8'h44};
    logic [7:0] es [5] = '{8'h1B, 8'h0B, 8'h29, 8'h19, 8'h39};
    wr(hcs_pkg::HCS_OFF_CTRL, 8'hC0);
    tick();
    tick();
    chk("rx starts", {7'h00, rx_active}, 8'h01);
    rxb(8'h2A, 1'b1, 1'b0, 1'b0);
    rxb(8'h11, 1'b0, 1'b0, 1'b0);
    rxb(8'h22, 1'b0, 1'b1, 1'b0);
    rxb(8'h30, 1'b1, 1'b0, 1'b0);
    rxb(8'h33, 1'b0, 1'b1, 1'b0);
    rxb(8'hFE, 1'b1, 1'b0, 1'b0);
    rxb(8'h44, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      rd(hcs_pkg::HCS_OFF_STAT, v);
      chk("rx head status", v, es[i]);
      rd(hcs_pkg::HCS_OFF_DATA, v);
      chk("rx byte", v, eb[i]);
    end
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("rx empty", v, 8'h08);
    $display("test rx done");
  endtask : t_rx
  task automatic t_idle_irq();
    logic [7:0] v;
    rxbits(14, 1'b1);
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("idle short run", v, 8'h08);
    rxbits(1, 1'b1);
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("idle detected", v, 8'h48);
    rxbits(1, 1'b0);
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("idle cleared", v, 8'h08);
    @(posedge clk) irq_masked <= 1'b1;
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("irq shown", v, 8'h88);
    @(posedge clk) irq_masked <= 1'b0;
    rd(hcs_pkg::HCS_OFF_STAT, v);
    chk("irq gone", v, 8'h08);
    $display("test idle irq done");
  endtask : t_idle_irq
  task automatic t_rxoff();
    rxb(8'hFE, 1'b1, 1'b0, 1'b0);
    wr(hcs_pkg::HCS_OFF_CTRL, 8'h00);
    tick();
    tick();
    chk("rx held in frame", {7'h00, rx_active}, 8'h01);
    rxb(8'h01, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 10 && rx_active !== 1'b0; i++) tick();
    chk("rx stops", {7'h00, rx_active}, 8'h00);
    $display("test rx off done");
  endtask : t_rxoff
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_txlev();
    t_txrun();
    t_fill();
    t_rx();
    t_idle_irq();
    t_rxoff();
    wrap_up();
  end
endmodule : hcs_top_test
`default_nettype wire
